// *** hdl/hpf_cfg.svh ***
// offsets, field positions, reset values and timing counts of the host controller
// assumes a 50 MHz clock and 32-bit APB data
`ifndef HPF_CFG_SVH
`define HPF_CFG_SVH

`define HPF_OFF_CTRL      8'h00
`define HPF_OFF_TX        8'h04
`define HPF_OFF_STATUS    8'h08
`define HPF_OFF_RXCFG     8'h0C
`define HPF_OFF_REFRESH   8'h10
`define HPF_OFF_RXDATA    8'h40
`define HPF_RXDATA_LAST   8'h7C

`define HPF_CTRL_AUTO     0
`define HPF_ST_BUSY       0
`define HPF_ST_STATNEW    1
`define HPF_ST_RXDONE     2
`define HPF_ST_PORTREQ    3
`define HPF_ST_BYTE_LSB   8
`define HPF_ST_CNT_LSB    16

`define HPF_FUNC_CMD      2'h3
`define HPF_FUNC_DATA     2'h0

`define HPF_RST_REFRESH   8'h00
`define HPF_RST_EXPECT    5'h10

`define HPF_CLK_KHZ       50000
`define HPF_REFRESH_MS    500

`endif

// *** hdl/hpf_pkg.sv ***
// types of the host controller for the parallel fan-out port
// assumes hpf_cfg.svh for all numbers
`default_nettype none
package hpf_pkg;

	typedef enum logic [2:0] {
		ST_IDLE     = 3'b000,
		ST_TX_REQ   = 3'b001,
		ST_TX_DRIVE = 3'b010,
		ST_TX_SETUP = 3'b011,
		ST_RX_RESP  = 3'b100,
		ST_RX_WAIT  = 3'b101
	} hpf_state_t;

	typedef struct packed {
		logic [15:0][7:0] mem;
		logic [7:0]       rdata;
	} hpf_mem_t;

	typedef struct packed {
		hpf_state_t  st;
		logic [2:0]  req_s;
		logic [2:0]  resp_s;
		logic [2:0]  valid_s;
		logic [2:0][15:0] data_s;
		logic [2:0][1:0]  func_s;
		logic        req_f;
		logic        resp_f;
		logic        valid_f;
		logic        host_req;
		logic        resp_o;
		logic        resp_oe;
		logic [15:0] data_o;
		logic        data_oe;
		logic [1:0]  func_o;
		logic        func_oe;
		logic        valid_o;
		logic        valid_oe;
		logic        tx_pend;
		logic [17:0] tx_word;
		logic        auto_en;
		logic        auto_pend;
		logic [24:0] refresh_cnt;
		logic [7:0]  refresh_byte;
		logic [7:0]  stat_byte;
		logic        stat_new;
		logic [4:0]  rx_cnt;
		logic [4:0]  rx_expect;
		logic        rx_done;
		logic        mem_we;
		logic [3:0]  mem_waddr;
		logic [7:0]  mem_wdata;
		logic        pready;
		logic [31:0] prdata;
		logic        pslverr;
	} hpf_main_t;

endpackage : hpf_pkg
`default_nettype wire

// *** hdl/hpf_rx_mem.sv ***
// sixteen-byte store for data bytes received from the port
// assumes one clock, clock enable from the controller
`timescale 1ns/1ns
`default_nettype none
module hpf_rx_mem (
	input  wire logic       i_clock,
	input  wire logic       i_nrst,
	input  wire logic       i_clk_en,
	input  wire logic       i_we,
	input  wire logic [3:0] i_waddr,
	input  wire logic [7:0] i_wdata,
	input  wire logic [3:0] i_raddr,
	output logic      [7:0] o_rdata
);
	hpf_pkg::hpf_mem_t r_reg;
	hpf_pkg::hpf_mem_t r_next;

	always_comb begin
		r_next = r_reg;
		if (i_we) begin
			r_next.mem[i_waddr] = i_wdata;
		end
		r_next.rdata = r_reg.mem[i_raddr];
	end

	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			r_reg <= '0;
		end else if (i_clk_en) begin
			r_reg <= r_next;
		end
	end

	assign o_rdata = r_reg.rdata;
endmodule : hpf_rx_mem
`default_nettype wire

// *** hdl/hpf_host.sv ***
// host-side controller driving the parallel fan-out port through its handshake pins
// assumes the port on the far side, pins asynchronous to i_clock, APB master on this side
//
// Function
// - status unprompted; data only after request
// - host refreshes servo watchdog periodically
// - port answers send request, releases its drivers
// - host drives data, function, then valid
`timescale 1ns/1ns
`default_nettype none
`include "hpf_cfg.svh"
module hpf_host #(
	parameter int unsigned REFRESH_CYCLES = `HPF_REFRESH_MS * `HPF_CLK_KHZ
) (
	input  wire logic        i_clock,
	input  wire logic        i_nrst,
	input  wire logic        i_clk_en,
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [7:0]  i_paddr,
	input  wire logic [31:0] i_pwdata,
	output logic      [31:0] o_prdata,
	output logic             o_pready,
	output logic             o_pslverr,
	output logic             o_host_send_request,
	input  wire logic        i_port_send_request,
	input  wire logic        i_port_response,
	output logic             o_port_response,
	output logic             o_port_response_oe,
	input  wire logic [15:0] i_data,
	output logic      [15:0] o_data,
	output logic             o_data_oe,
	input  wire logic        i_function_bit_low,
	input  wire logic        i_function_bit_high,
	output logic             o_function_bit_low,
	output logic             o_function_bit_high,
	output logic             o_function_oe,
	input  wire logic        i_valid,
	output logic             o_valid,
	output logic             o_valid_oe
);
	hpf_pkg::hpf_main_t r_reg;
	hpf_pkg::hpf_main_t r_next;
	logic [7:0]         mem_rdata;

	function automatic logic hpf_mapped(input logic [7:0] a);
		hpf_mapped = (a == `HPF_OFF_CTRL) || (a == `HPF_OFF_TX) || (a == `HPF_OFF_STATUS)
			|| (a == `HPF_OFF_RXCFG) || (a == `HPF_OFF_REFRESH)
			|| ((a >= `HPF_OFF_RXDATA) && (a <= `HPF_RXDATA_LAST) && (a[1:0] == 2'h0));
	endfunction : hpf_mapped

	// agreed change of the second and third stage only
	function automatic logic hpf_filt(input logic [2:0] s, input logic f);
		hpf_filt = (s[1] == s[2]) ? s[2] : f;
	endfunction : hpf_filt

	hpf_rx_mem u_rx_mem (
		.i_clock  (i_clock),
		.i_nrst   (i_nrst),
		.i_clk_en (i_clk_en),
		.i_we     (r_reg.mem_we),
		.i_waddr  (r_reg.mem_waddr),
		.i_wdata  (r_reg.mem_wdata),
		.i_raddr  (i_paddr[5:2]),
		.o_rdata  (mem_rdata)
	);

	always_comb begin
		logic        acc;
		logic        wr;
		logic [31:0] rd;
		logic        clr_stat;
		logic        clr_done;
		logic [1:0]  fcode;
		acc      = i_psel && i_penable;
		wr       = acc && r_reg.pready && i_pwrite && hpf_mapped(i_paddr);
		rd       = 32'h0000_0000;
		clr_stat = 1'b0;
		clr_done = 1'b0;
		fcode    = r_reg.func_s[2];
		r_next   = r_reg;
		r_next.mem_we = 1'b0;

		// pin synchronisers
		r_next.req_s   = {r_reg.req_s[1:0], i_port_send_request};
		r_next.resp_s  = {r_reg.resp_s[1:0], i_port_response};
		r_next.valid_s = {r_reg.valid_s[1:0], i_valid};
		r_next.data_s  = {r_reg.data_s[1:0], i_data};
		r_next.func_s  = {r_reg.func_s[1:0], i_function_bit_high, i_function_bit_low};
		r_next.req_f   = hpf_filt(r_reg.req_s, r_reg.req_f);
		r_next.resp_f  = hpf_filt(r_reg.resp_s, r_reg.resp_f);
		r_next.valid_f = hpf_filt(r_reg.valid_s, r_reg.valid_f);

		// register reads
		case (i_paddr)
			`HPF_OFF_CTRL: begin
				rd[`HPF_CTRL_AUTO] = r_reg.auto_en;
			end
			`HPF_OFF_TX: begin
				rd[17:0] = r_reg.tx_word;
			end
			`HPF_OFF_STATUS: begin
				rd[`HPF_ST_BUSY]    = r_reg.tx_pend || (r_reg.st != hpf_pkg::ST_IDLE);
				rd[`HPF_ST_STATNEW] = r_reg.stat_new;
				rd[`HPF_ST_RXDONE]  = r_reg.rx_done;
				rd[`HPF_ST_PORTREQ] = r_reg.req_f;
				rd[`HPF_ST_BYTE_LSB +: 8] = r_reg.stat_byte;
				rd[`HPF_ST_CNT_LSB +: 5]  = r_reg.rx_cnt;
			end
			`HPF_OFF_RXCFG: begin
				rd[4:0] = r_reg.rx_expect;
			end
			`HPF_OFF_REFRESH: begin
				rd[7:0] = r_reg.refresh_byte;
			end
			default: begin
				rd[7:0] = hpf_mapped(i_paddr) ? mem_rdata : 8'h00;
			end
		endcase

		// apb slave: one wait state, then pready for one cycle
		if (acc && !r_reg.pready) begin
			r_next.pready  = 1'b1;
			r_next.prdata  = i_pwrite ? 32'h0000_0000 : rd;
			r_next.pslverr = !hpf_mapped(i_paddr);
		end else begin
			r_next.pready  = 1'b0;
			r_next.pslverr = 1'b0;
		end

		if (wr) begin
			case (i_paddr)
				`HPF_OFF_CTRL: begin
					r_next.auto_en = i_pwdata[`HPF_CTRL_AUTO];
				end
				`HPF_OFF_TX: begin
					if (!r_reg.tx_pend) begin
						r_next.tx_word = i_pwdata[17:0];
						r_next.tx_pend = 1'b1;
					end
				end
				`HPF_OFF_STATUS: begin
					clr_stat = i_pwdata[`HPF_ST_STATNEW];
					clr_done = i_pwdata[`HPF_ST_RXDONE];
				end
				`HPF_OFF_RXCFG: begin
					r_next.rx_expect = i_pwdata[4:0];
					r_next.rx_cnt    = 5'h00;
					clr_done         = 1'b1;
				end
				`HPF_OFF_REFRESH: begin
					r_next.refresh_byte = i_pwdata[7:0];
				end
				default: begin
				end
			endcase
		end
		if (clr_stat) begin
			r_next.stat_new = 1'b0;
		end
		if (clr_done) begin
			r_next.rx_done = 1'b0;
		end

		// periodic watchdog refresh command
		if (!r_reg.auto_en) begin
			r_next.refresh_cnt = 25'h000_0000;
			r_next.auto_pend   = 1'b0;
		end else if (r_reg.refresh_cnt == 25'(REFRESH_CYCLES - 1)) begin
			r_next.refresh_cnt = 25'h000_0000;
			r_next.auto_pend   = 1'b1;
		end else begin
			r_next.refresh_cnt = r_reg.refresh_cnt + 25'h000_0001;
		end

		case (r_reg.st)
			hpf_pkg::ST_IDLE: begin
				if (r_reg.req_f) begin
					// answer the port first: it is only talking when it has to
					r_next.st       = hpf_pkg::ST_RX_RESP;
					r_next.resp_o   = 1'b1;
					r_next.resp_oe  = 1'b1;
				end else if (r_reg.tx_pend || r_reg.auto_pend) begin
					if (!r_reg.tx_pend) begin
						r_next.tx_word   = {`HPF_FUNC_CMD, 8'h00, r_reg.refresh_byte};
						r_next.tx_pend   = 1'b1;
						r_next.auto_pend = 1'b0;
					end
					r_next.st       = hpf_pkg::ST_TX_REQ;
					r_next.host_req = 1'b1;
				end
			end
			hpf_pkg::ST_TX_REQ: begin
				if (r_reg.resp_f) begin
					r_next.st      = hpf_pkg::ST_TX_SETUP;
					r_next.data_o  = r_reg.tx_word[15:0];
					r_next.data_oe = 1'b1;
					r_next.func_o  = r_reg.tx_word[17:16];
					r_next.func_oe = 1'b1;
				end
			end
			hpf_pkg::ST_TX_SETUP: begin
				r_next.st       = hpf_pkg::ST_TX_DRIVE;
				r_next.valid_o  = 1'b1;
				r_next.valid_oe = 1'b1;
			end
			hpf_pkg::ST_TX_DRIVE: begin
				if (!r_reg.resp_f) begin
					// response withdrawn: the word has been strobed
					r_next.st       = hpf_pkg::ST_IDLE;
					r_next.host_req = 1'b0;
					r_next.valid_o  = 1'b0;
					r_next.valid_oe = 1'b0;
					r_next.data_oe  = 1'b0;
					r_next.func_oe  = 1'b0;
					r_next.tx_pend  = 1'b0;
				end
			end
			hpf_pkg::ST_RX_RESP: begin
				if (r_reg.valid_f) begin
					r_next.st     = hpf_pkg::ST_RX_WAIT;
					r_next.resp_o = 1'b0;
					if (fcode == `HPF_FUNC_CMD) begin
						r_next.stat_byte = r_reg.data_s[2][7:0];
						r_next.stat_new  = 1'b1;
					end else if ((fcode == `HPF_FUNC_DATA) && !r_reg.rx_cnt[4]) begin
						r_next.mem_we    = 1'b1;
						r_next.mem_waddr = r_reg.rx_cnt[3:0];
						r_next.mem_wdata = r_reg.data_s[2][7:0];
						r_next.rx_cnt    = r_reg.rx_cnt + 5'h01;
						if ((r_reg.rx_cnt + 5'h01) == r_reg.rx_expect) begin
							r_next.rx_done = 1'b1;
						end
					end
				end
			end
			hpf_pkg::ST_RX_WAIT: begin
				if (!r_reg.valid_f) begin
					r_next.st      = hpf_pkg::ST_IDLE;
					r_next.resp_oe = 1'b0;
				end
			end
			default: begin
				r_next.st = hpf_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			r_reg              <= '0;
			r_reg.refresh_byte <= `HPF_RST_REFRESH;
			r_reg.rx_expect    <= `HPF_RST_EXPECT;
		end else if (i_clk_en) begin
			r_reg <= r_next;
		end
	end

	assign o_prdata            = r_reg.prdata;
	assign o_pready            = r_reg.pready;
	assign o_pslverr           = r_reg.pslverr;
	assign o_host_send_request = r_reg.host_req;
	assign o_port_response     = r_reg.resp_o;
	assign o_port_response_oe  = r_reg.resp_oe;
	assign o_data              = r_reg.data_o;
	assign o_data_oe           = r_reg.data_oe;
	assign o_function_bit_low  = r_reg.func_o[0];
	assign o_function_bit_high = r_reg.func_o[1];
	assign o_function_oe       = r_reg.func_oe;
	assign o_valid             = r_reg.valid_o;
	assign o_valid_oe          = r_reg.valid_oe;
endmodule : hpf_host
`default_nettype wire

// *** verification/hpf_host_checker.sv ***
// assertions on the pins and APB answer of the host controller
// assumes one clock domain; bound onto hpf_host
`timescale 1ns/1ns
`default_nettype none
module hpf_host_checker (
	input wire logic        i_clock,
	input wire logic        i_nrst,
	input wire logic        i_clk_en,
	input wire logic        i_psel,
	input wire logic        i_penable,
	input wire logic        o_pready,
	input wire logic        o_pslverr,
	input wire logic        i_port_send_request,
	input wire logic        i_port_response,
	input wire logic        o_port_response,
	input wire logic        o_port_response_oe,
	input wire logic        o_host_send_request,
	input wire logic [15:0] o_data,
	input wire logic        o_data_oe,
	input wire logic        o_function_oe,
	input wire logic        i_valid,
	input wire logic        o_valid,
	input wire logic        o_valid_oe
);
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_nrst);
	chk_apb_one_wait: assert property (i_clk_en && i_psel && i_penable && !o_pready |=> o_pready)
		else $error("pready late");
	chk_apb_pulse: assert property (o_pready |=> !o_pready)
		else $error("pready held");
	chk_slverr_with: assert property (o_pslverr |-> o_pready && $past(i_penable))
		else $error("stray slverr");
	chk_data_first: assert property ($rose(o_valid) |-> $past(o_data_oe) && o_function_oe)
		else $error("valid before data");
	chk_drive_on_resp: assert property ($rose(o_data_oe) |-> o_host_send_request && $past(i_port_response))
		else $error("data driven unasked");
	chk_hold_data: assert property (o_valid && i_port_response |=> o_valid && $stable(o_data))
		else $error("data moved");
	chk_release_bus: assert property ($fell(i_port_response) && o_valid |-> ##[1:8] !o_valid_oe && !o_host_send_request)
		else $error("bus not released");
	chk_no_fight: assert property (o_port_response_oe |-> !o_data_oe && !o_valid_oe && !o_function_oe)
		else $error("both drive");
	chk_answer_req: assert property ($rose(o_port_response) |-> $past(i_port_send_request))
		else $error("response unasked");
	chk_drop_resp: assert property (o_port_response && i_valid |-> ##[1:8] !o_port_response)
		else $error("response stuck");
	cover property ($rose(o_valid));
	cover property ($rose(o_port_response));
	cover property (o_pslverr);
endmodule : hpf_host_checker
bind hpf_host hpf_host_checker i_hpf_host_checker (.i_clock, .i_nrst, .i_clk_en, .i_psel, .i_penable,
	.o_pready, .o_pslverr, .i_port_send_request, .i_port_response, .o_port_response,
	.o_port_response_oe, .o_host_send_request, .o_data, .o_data_oe, .o_function_oe, .i_valid,
	.o_valid, .o_valid_oe);
`default_nettype wire

// *** verification/hpf_port_model.sv ***
// behavioural fan-out port facing the host controller
// assumes lines resolved by the bench, low when released
`timescale 1ns/1ns
`default_nettype none
module hpf_port_model (
	input  wire logic        i_clock,
	input  wire logic        i_host_send_request,
	input  wire logic        i_response,
	input  wire logic        i_valid,
	input  wire logic [15:0] i_data,
	input  wire logic [1:0]  i_func,
	input  wire logic        i_timeout,
	input  wire logic        i_avail,
	input  wire logic [4:0]  i_count,
	input  wire logic        i_slow,
	output logic             o_send_request,
	output logic             o_response,
	output logic             o_drive,
	output logic      [7:0]  o_data,
	output logic      [1:0]  o_func
);
	logic [7:0]  status = 8'h50;
	logic [15:0] last_word;
	logic [1:0]  last_func;
	logic        jam;
	int          lag;
	task automatic take_word;
		repeat (lag) @(posedge i_clock);
		o_response <= 1'h1;
		while (!i_valid) @(posedge i_clock);
		repeat (lag) @(posedge i_clock);
		last_word = i_data;
		last_func = i_func;
		jam = (i_func == 2'h3);
		status = status + {7'h0, jam};
		o_response <= 1'h0;
		while (i_host_send_request) @(posedge i_clock);
	endtask : take_word
	task automatic send(input logic [7:0] b, input logic [1:0] f);
		o_send_request <= 1'h1;
		while (!i_response) @(posedge i_clock);
		repeat (lag) @(posedge i_clock);
		o_data <= b;
		o_func <= f;
		o_drive <= 1'h1;
		@(posedge i_clock);
		while (i_response) @(posedge i_clock);
		o_drive <= 1'h0;
	endtask : send
	initial begin
		{o_send_request, o_response, o_drive, o_data, o_func, jam} = '0;
		forever begin
			@(posedge i_clock);
			lag = i_slow ? 12 : 1;
			if (i_host_send_request)
				take_word();
			else if (i_timeout)
				jam = 1'h1;
			else if (i_avail) begin
				for (int k = 0; k < i_count; k++)
					send(8'hC0 + k[7:0], 2'h0);
				o_send_request <= 1'h0;
			end
			if (jam) begin
				send(status, 2'h3);
				o_send_request <= 1'h0;
				jam = 1'h0;
			end
		end
	end
endmodule : hpf_port_model
`default_nettype wire

// *** verification/hpf_host_tb.sv ***
// self-checking bench: host controller against a behavioural fan-out port
// assumes hpf_host, hpf_port_model and the bound checker
`timescale 1ns/1ns
`default_nettype none
`include "hpf_cfg.svh"
module hpf_host_tb;
	logic        clk = 0, nrst = 0, psel = 0, pen = 0, pwr = 0, tmo = 0, av = 0, slow = 0, en = 1;
	logic        rerr, pready, pslverr, hreq, hresp, hresp_oe, doe, fl, fh, foe, hval, hval_oe;
	logic        mreq, mresp, mdrv;
	logic [7:0]  paddr = 8'h00, mdata, ncmd = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [4:0]  cnt = 5'h0;
	logic [15:0] hdata;
	logic [1:0]  mfunc;
	wire logic        resp_w = hresp_oe ? hresp : mresp;
	wire logic        valid_w = hval_oe ? hval : mdrv;
	wire logic [15:0] data_w = doe ? hdata : mdrv ? {8'h00, mdata} : 16'h0;
	wire logic [1:0]  func_w = foe ? {fh, fl} : mdrv ? mfunc : 2'h0;
	int num_errors = 0, check_count = 0, cycles = 0;
	hpf_host #(.REFRESH_CYCLES(200)) i_hpf_host (.i_clock(clk), .i_nrst(nrst), .i_clk_en(en),
		.i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
		.o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .o_host_send_request(hreq),
		.i_port_send_request(mreq), .i_port_response(resp_w), .o_port_response(hresp),
		.o_port_response_oe(hresp_oe), .i_data(data_w), .o_data(hdata), .o_data_oe(doe),
		.i_function_bit_low(func_w[0]), .i_function_bit_high(func_w[1]), .o_function_bit_low(fl),
		.o_function_bit_high(fh), .o_function_oe(foe), .i_valid(valid_w), .o_valid(hval),
		.o_valid_oe(hval_oe));
	hpf_port_model i_hpf_port_model (.i_clock(clk), .i_host_send_request(hreq), .i_response(resp_w),
		.i_valid(valid_w), .i_data(data_w), .i_func(func_w), .i_timeout(tmo), .i_avail(av),
		.i_count(cnt), .i_slow(slow), .o_send_request(mreq), .o_response(mresp), .o_drive(mdrv),
		.o_data(mdata), .o_func(mfunc));
	always #10 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		if (cycles == 60000) begin
			num_errors++;
			conclude();
		end
	end
	task automatic conclude;
		$display("errors %0d checks %0d", num_errors, check_count);
		if (num_errors == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : conclude
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'h1;
		pwr <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'h1;
		@(posedge clk);
		while (pready !== 1'h1) @(posedge clk);
		rd = prdata;
		rerr = pslverr;
		psel <= 1'h0;
		pen <= 1'h0;
		@(posedge clk);
	endtask : apb
	task automatic wait_bit(input int b, input logic v);
		int n;
		n = 0;
		do begin
			apb(1'h0, `HPF_OFF_STATUS, 32'h0);
			n++;
		end while (rd[b] !== v && n < 400);
		check("waited", {31'h0, v}, {31'h0, rd[b]});
	endtask : wait_bit
	task automatic s_freeze;
		en <= 1'h0;
		fork
			apb(1'h0, `HPF_OFF_RXCFG, 32'h0);
			begin
				repeat (6) @(posedge clk);
				check("frozen", 32'h0, {31'h0, pready});
				en <= 1'h1;
			end
		join
		check("thaw", {27'h0, `HPF_RST_EXPECT}, rd);
	endtask : s_freeze
	task automatic s_reset;
		check("pins", 32'h0, {27'h0, doe, foe, hval_oe, hresp_oe, hreq});
		apb(1'h0, `HPF_OFF_RXCFG, 32'h0);
		check("rxcfg", {27'h0, `HPF_RST_EXPECT}, rd);
		apb(1'h0, `HPF_OFF_REFRESH, 32'h0);
		check("refresh", {24'h0, `HPF_RST_REFRESH}, rd);
		apb(1'h1, 8'h20, 32'h1234);
		check("slverr", 32'h1, {31'h0, rerr});
	endtask : s_reset
	task automatic s_cmds;
		for (int s = 0; s < 8; s++) begin
			apb(1'h1, `HPF_OFF_TX, {14'h0, `HPF_FUNC_CMD, 8'h0, s[2:0], 5'h0B});
			ncmd++;
			wait_bit(`HPF_ST_STATNEW, 1'h1);
			check("status", {24'h0, 8'h50 + ncmd}, {24'h0, rd[15:8]});
			check("sel", s, {29'h0, i_hpf_port_model.last_word[7:5]});
			check("func", 32'h3, {30'h0, i_hpf_port_model.last_func});
			apb(1'h1, `HPF_OFF_STATUS, 32'h2);
		end
	endtask : s_cmds
	task automatic s_word;
		for (int f = 1; f < 3; f++) begin
			apb(1'h1, `HPF_OFF_TX, {14'h0, f[1:0], 16'hA5C3});
			wait_bit(`HPF_ST_BUSY, 1'h0);
			check("word", 32'hA5C3, {16'h0, i_hpf_port_model.last_word});
			check("wfunc", f, {30'h0, i_hpf_port_model.last_func});
			check("nojam", 32'h0, {31'h0, rd[`HPF_ST_STATNEW]});
		end
	endtask : s_word
	task automatic s_timeout;
		tmo <= 1'h1;
		@(posedge clk);
		tmo <= 1'h0;
		wait_bit(`HPF_ST_STATNEW, 1'h1);
		check("tstatus", {24'h0, 8'h50 + ncmd}, {24'h0, rd[15:8]});
		apb(1'h1, `HPF_OFF_STATUS, 32'h2);
	endtask : s_timeout
	task automatic s_data(input logic sl, input logic [4:0] n);
		slow <= sl;
		apb(1'h1, `HPF_OFF_RXCFG, {27'h0, n});
		av <= 1'h1;
		cnt <= n;
		@(posedge clk);
		av <= 1'h0;
		wait_bit(`HPF_ST_RXDONE, 1'h1);
		check("count", {27'h0, n}, {27'h0, rd[20:16]});
		for (int i = 0; i < n; i++) begin
			apb(1'h0, `HPF_OFF_RXDATA + 8'(4 * i), 32'h0);
			check("byte", 32'hC0 + i, rd);
		end
	endtask : s_data
	task automatic s_refresh;
		apb(1'h1, `HPF_OFF_REFRESH, 32'h3A);
		apb(1'h1, `HPF_OFF_CTRL, 32'h1);
		wait_bit(`HPF_ST_STATNEW, 1'h1);
		check("refcmd", 32'h3A, {24'h0, i_hpf_port_model.last_word[7:0]});
		check("reffunc", 32'h3, {30'h0, i_hpf_port_model.last_func});
	endtask : s_refresh
	initial begin
		repeat (4) @(posedge clk);
		nrst <= 1'h1;
		@(posedge clk);
		s_reset();
		s_freeze();
		s_cmds();
		s_word();
		s_timeout();
		s_data(1'h0, 5'h03);
		s_data(1'h1, 5'h10);
		s_refresh();
		conclude();
	end
endmodule : hpf_host_tb
`default_nettype wire
